// ### verif/meter_config_registers_bench.sv
`timescale 1ns/10ps
`default_nettype none
`include "meter_config_params.svh"
// --------------------------------------------------------
// bench for the configuration register bank
// --------------------------------------------------------
module meter_config_registers_bench import meter_config_pkg::*;;
	localparam logic [12:0] A0 = {`CFG0_INDEX, 2'h0};
	localparam logic [12:0] A1 = {`CFG1_INDEX, 2'h0};
	localparam logic [12:0] A2 = {`CFG2_INDEX, 2'h0};
	// pin level per source code for the stimulus set in t_pins
	localparam logic [15:0] SRC_VAL = 16'h0a65;
	// codes that leave the pin undriven, reserved ones included
	localparam logic [15:0] HIZ     = 16'h6408;
	logic        pclk = 1'h0, presetn = 1'h0, ce = 1'h1;
	logic        psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic [12:0] paddr = 13'h0;
	logic [31:0] pwdata = 32'h0, prdata;
	logic        pready, pslverr, irq_event = 1'h0, irq_out;
	logic [2:0]  pulse_gen_in = 3'h0, out_pin_o, out_pin_oe_n;
	logic [5:0]  power_sign_in = 6'h0;
	logic        volt_zero_cross_in = 1'h0, cur1_zero_cross_in = 1'h0;
	logic        cur2_zero_cross_in = 1'h1, freq_meas_done = 1'h0;
	logic        cur_zero_cross_out, volt_zero_cross_out;
	logic [23:0] p1_avg_in = 24'h0, p2_avg_in = 24'h0, i1_rms_in = 24'h0;
	logic [23:0] i2_rms_in = 24'h0, p1_avg_out, p2_avg_out;
	logic        sum_use_ch2, sum_average, epsilon_update, xtal_disable;
	logic [2:0]  pulse_gen_enable;
	gain_code_t  cur1_amp_gain, cur2_amp_gain;
	logic        fixed_voltage_ref, apparent_power_method, iir_bypass;
	logic        averaging_select, checksum_line_cycles;
	logic        critical_checksum_disable;
	filt_code_t  cur1_filter_sel, cur2_filter_sel;
	filt_code_t  volt1_filter_sel, volt2_filter_sel;
	int          err_count = 0, samples_checked = 0;

	meter_config_registers DUT (.pclk, .presetn, .ce, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq_event,
		.irq_out, .pulse_gen_in, .power_sign_in, .volt_zero_cross_in,
		.cur1_zero_cross_in, .cur2_zero_cross_in, .cur_zero_cross_out,
		.volt_zero_cross_out, .out_pin_o, .out_pin_oe_n, .p1_avg_in,
		.p2_avg_in, .i1_rms_in, .i2_rms_in, .p1_avg_out, .p2_avg_out,
		.sum_use_ch2, .sum_average, .freq_meas_done, .epsilon_update,
		.pulse_gen_enable, .cur1_amp_gain, .cur2_amp_gain, .xtal_disable,
		.fixed_voltage_ref, .apparent_power_method, .averaging_select,
		.checksum_line_cycles, .critical_checksum_disable,
		.cur1_filter_sel, .cur2_filter_sel, .volt1_filter_sel,
		.volt2_filter_sel, .iir_bypass);

	always #2 pclk = ~pclk;

	// --------------------------------------------------------
	// shared tasks
	// --------------------------------------------------------
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : print_verdict

	task automatic chk(input string nm, input logic [31:0] e, g);
		samples_checked++;
		if (g !== e) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// answers are read right after the rising edge, before any flop moves
	task automatic apb(input logic w, input logic [12:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic se);
		int n;
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'h1 && n < 64);
		q = prdata;
		se = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		if (n >= 64) chk("pready", 1, 0);
	endtask : apb

	task automatic wr(input logic [12:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic        se;
		apb(1'h1, a, d, q, se);
		chk("write err", 0, se);
	endtask : wr

	task automatic rd(input logic [12:0] a, input logic [31:0] e,
		input string nm);
		logic [31:0] q;
		logic        se;
		apb(1'h0, a, 32'h0, q, se);
		chk(nm, e, q);
		chk("read err", 0, se);
	endtask : rd

	task automatic settle;
		repeat (6) @(posedge pclk);
		#1;
	endtask : settle

	task automatic freq(input logic [3:0] e);
		logic [3:0] n;
		n = 4'h0;
		@(posedge pclk);
		freq_meas_done <= 1'h1;
		repeat (4) begin
			@(posedge pclk);
			freq_meas_done <= 1'h0;
			#1;
			n = n + epsilon_update;
		end
		chk("epsilon pulses", e, n);
	endtask : freq

	// one-cycle glitch on the voltage zero-cross input
	task automatic glitch(input logic e);
		logic [3:0] n;
		@(posedge pclk);
		volt_zero_cross_in <= 1'h0;
		repeat (8) @(posedge pclk);
		volt_zero_cross_in <= 1'h1;
		n = 4'h0;
		repeat (8) begin
			@(posedge pclk);
			volt_zero_cross_in <= 1'h0;
			#1;
			n = n + volt_zero_cross_out;
		end
		chk("zc glitch seen", e, n != 4'h0);
	endtask : glitch

	// --------------------------------------------------------
	// scenarios
	// --------------------------------------------------------
	task automatic t_reset;
		rd(A0, `CFG0_RESET, "word zero");
		rd(A1, `CFG1_RESET, "word one");
		rd(A2, `CFG2_RESET, "word two");
		chk("oe_n", 3'h7, out_pin_oe_n);
		chk("irq idle", 1, irq_out);
		chk("gains", 0, {cur1_amp_gain, cur2_amp_gain});
		chk("pgen en", 0, pulse_gen_enable);
		chk("cur zc", 0, cur_zero_cross_out);
		chk("flags", 0, {
			xtal_disable, fixed_voltage_ref, iir_bypass,
			apparent_power_method, averaging_select,
			critical_checksum_disable});
	endtask : t_reset

	task automatic t_word0;
		logic [31:0] q;
		logic        se;
		apb(1'h0, 13'h0008, 32'h0, q, se);
		chk("unmapped data", 0, q);
		chk("unmapped err", 1, se);
		// every writable bit set, fixed bits kept at their published level
		wr(A0, `CFG0_RESET | `CFG0_WMASK);
		rd(A0, `CFG0_RESET | `CFG0_WMASK, "all writable");
		@(posedge pclk);
		irq_event <= 1'h1;
		wr(A0, 32'hc021a6);
		settle;
		chk("irq high", 1, irq_out);
		chk("gains", 4'ha, {cur1_amp_gain, cur2_amp_gain});
		chk("xtal", 1, xtal_disable);
		chk("cur zc ch2", 1, cur_zero_cross_out);
		@(posedge pclk);
		irq_event <= 1'h0;
		settle;
		chk("irq low", 0, irq_out);
		wr(A0, `CFG0_RESET);
	endtask : t_word0

	task automatic t_pins;
		logic v;
		@(posedge pclk);
		pulse_gen_in <= 3'h5;
		power_sign_in <= 6'h26;
		volt_zero_cross_in <= 1'h1;
		irq_event <= 1'h1;
		for (int od = 0; od < 2; od++) begin
			for (int c = 0; c < 16; c++) begin
				wr(A1, {8'h0, 4'h7, 1'h0, {3{od[0]}}, 4'he,
					{3{c[3:0]}}});
				settle;
				v = SRC_VAL[c];
				if (HIZ[c]) begin
					chk("hiz oe_n", 3'h7, out_pin_oe_n);
				end else if (od != 0) begin
					chk("od oe_n", {3{v}}, out_pin_oe_n);
					chk("od o", 0, out_pin_o);
				end else begin
					chk("pp oe_n", 0, out_pin_oe_n);
					chk("pp o", {3{v}}, out_pin_o);
				end
			end
		end
		chk("pgen en", 3'h7, pulse_gen_enable);
		rd(A1, 32'h77efff, "word one");
		wr(A1, 32'h00e000);
		settle;
		chk("pgen off", 0, out_pin_o);
		chk("pgen en", 0, pulse_gen_enable);
	endtask : t_pins

	task automatic t_word2;
		@(posedge pclk);
		p1_avg_in <= 24'h800001;
		p2_avg_in <= 24'h000123;
		i1_rms_in <= 24'h000500;
		i2_rms_in <= 24'h000100;
		wr(A2, 32'hc04fc9);
		rd(A2, 32'hc04fc9, "word two");
		settle;
		chk("p1 clamp", 0, p1_avg_out);
		chk("p2 kept", 24'h123, p2_avg_out);
		chk("auto power", 1, sum_use_ch2);
		chk("flags", 6'h3f, {
			fixed_voltage_ref, apparent_power_method,
			averaging_select, checksum_line_cycles,
			critical_checksum_disable, iir_bypass});
		chk("filters", 8'he4, {cur2_filter_sel, volt2_filter_sel,
			cur1_filter_sel, volt1_filter_sel});
		freq(4'h1);
		wr(A2, 32'h080000);
		settle;
		chk("p1 signed", 24'h800001, p1_avg_out);
		chk("auto rms", 0, sum_use_ch2);
		chk("single", 0, sum_average);
		chk("flags", 0, {
			fixed_voltage_ref, apparent_power_method,
			averaging_select, checksum_line_cycles,
			critical_checksum_disable, iir_bypass});
		freq(4'h0);
		glitch(1'h1);
		// automatic choice would pick channel 1 here, the hold must win
		wr(A2, 32'h381200);
		settle;
		chk("manual ch2", 1, sum_use_ch2);
		glitch(1'h0);
		// automatic choice would pick channel 2 here, the hold must win
		wr(A2, 32'h101000);
		settle;
		chk("manual ch1", 0, sum_use_ch2);
		wr(A2, 32'h321200);
		settle;
		chk("average", 1, sum_average);
		chk("avg no ch2", 0, sum_use_ch2);
	endtask : t_word2

	// --------------------------------------------------------
	// main sequence and watchdog
	// --------------------------------------------------------
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'h1;
		t_reset;
		t_word0;
		t_pins;
		t_word2;
		print_verdict;
	end

	// the full run needs well under a fifth of this span
	initial begin
		#80000;
		err_count++;
		print_verdict;
	end
endmodule : meter_config_registers_bench
`default_nettype wire

// ### verilog/meter_config_params.svh
`ifndef METER_CONFIG_PARAMS_SVH
`define METER_CONFIG_PARAMS_SVH
// ----------------------------------------------------------------
// register map: index = page * 64 + address, byte address = 4 * index
// ----------------------------------------------------------------
`define CFG0_INDEX    11'h000
`define CFG1_INDEX    11'h001
`define CFG2_INDEX    11'h400
`define CFG_W         24
// ----------------------------------------------------------------
// reset values and writable-bit masks
// ----------------------------------------------------------------
`define CFG0_RESET    24'hc02000
`define CFG1_RESET    24'h00eeee
`define CFG2_RESET    24'h000200
`define CFG0_WMASK    24'h0001f6
`define CFG1_WMASK    24'h770fff
`define CFG2_WMASK    24'hfe5fff
// ----------------------------------------------------------------
// config word zero fields
// ----------------------------------------------------------------
`define C0_IRQ_POL    8
`define C0_CUR2_GAIN  6
`define C0_CUR1_GAIN  4
`define C0_XTAL_OFF   2
`define C0_IZX_SEL    1
// ----------------------------------------------------------------
// config word one fields
// ----------------------------------------------------------------
`define C1_PGEN_EN    20
`define C1_OPEN_DRAIN 16
`define C1_SRC        0
`define SRC_W         4
// ----------------------------------------------------------------
// config word two fields
// ----------------------------------------------------------------
`define C2_FIXED_VOLTAGE_REF       23
`define C2_POS        22
`define C2_ICHAN      21
`define C2_MANUAL_CHANNEL_HOLD      20
`define C2_COMPARE_BY_RMS_CURRENT       19
`define C2_METER_TOPOLOGY       17
`define C2_APPARENT_POWER_METHOD       14
`define C2_ZERO_CROSS_LOWPASS     12
`define C2_AVG        11
`define C2_CSUM_OFF   10
`define C2_AFC        9
`define C2_CUR2_FILTER_SEL      7
`define C2_VOLT2_FILTER_SEL      5
`define C2_CUR1_FILTER_SEL      3
`define C2_VOLT1_FILTER_SEL      1
`define C2_IIR_BYPASS    0
// ----------------------------------------------------------------
// output source codes and meter topology codes
// ----------------------------------------------------------------
`define SRC_PGEN_LAST 4'h2
`define SRC_SIGN_FIRST 4'h4
`define SRC_SIGN_LAST 4'h9
`define SRC_VOLT_ZX   4'hb
`define SRC_CUR_ZX    4'hc
`define SRC_HIZ       4'he
`define SRC_IRQ       4'hf
`define METER_TOPOLOGY_SINGLE   2'h0
`define METER_TOPOLOGY_AVERAGE  2'h1
`define ZX_FILT_LEN   3
`endif

// ### verilog/meter_config_pkg.sv
`default_nettype none
`include "meter_config_params.svh"
package meter_config_pkg;
	typedef logic [`CFG_W-1:0] cfg_word_t;
	typedef logic [1:0]        gain_code_t;
	typedef logic [1:0]        filt_code_t;
	typedef logic [1:0]        topo_code_t;
endpackage : meter_config_pkg
`default_nettype wire

// ### verilog/meter_config_registers.sv
`timescale 1ns/10ps
`default_nettype none
`include "meter_config_params.svh"

module meter_config_registers import meter_config_pkg::*; #(
	parameter int ADDR_W = 13,
	parameter int POW_W  = 24
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              ce,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output var  logic [31:0]       prdata,
	output var  logic              pready,
	output var  logic              pslverr,
	input  wire logic              irq_event,
	output var  logic              irq_out,
	input  wire logic [2:0]        pulse_gen_in,
	input  wire logic [5:0]        power_sign_in,
	input  wire logic              volt_zero_cross_in,
	input  wire logic              cur1_zero_cross_in,
	input  wire logic              cur2_zero_cross_in,
	output var  logic              cur_zero_cross_out,
	output var  logic              volt_zero_cross_out,
	output var  logic [2:0]        out_pin_o,
	output var  logic [2:0]        out_pin_oe_n,
	input  wire logic [POW_W-1:0]  p1_avg_in,
	input  wire logic [POW_W-1:0]  p2_avg_in,
	input  wire logic [POW_W-1:0]  i1_rms_in,
	input  wire logic [POW_W-1:0]  i2_rms_in,
	output var  logic [POW_W-1:0]  p1_avg_out,
	output var  logic [POW_W-1:0]  p2_avg_out,
	output var  logic              sum_use_ch2,
	output var  logic              sum_average,
	input  wire logic              freq_meas_done,
	output var  logic              epsilon_update,
	output var  logic [2:0]        pulse_gen_enable,
	output var  gain_code_t        cur1_amp_gain,
	output var  gain_code_t        cur2_amp_gain,
	output var  logic              xtal_disable,
	output var  logic              fixed_voltage_ref,
	output var  logic              apparent_power_method,
	output var  logic              averaging_select,
	output var  logic              checksum_line_cycles,
	output var  logic              critical_checksum_disable,
	output var  filt_code_t        cur1_filter_sel,
	output var  filt_code_t        cur2_filter_sel,
	output var  filt_code_t        volt1_filter_sel,
	output var  filt_code_t        volt2_filter_sel,
	output var  logic              iir_bypass
);
	if (ADDR_W < 13 || ADDR_W > 32 || POW_W < 2) begin : g_param_chk
		$error("ADDR_W must be 13 to 32 and POW_W at least 2");
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// ----------------------------------------------------------------
	// apb slave
	// ----------------------------------------------------------------
	cfg_word_t                cfg0_r;
	cfg_word_t                cfg1_r;
	cfg_word_t                cfg2_r;
	logic                     setup_done_r;
	logic [ADDR_W-3:0]        word_idx;
	logic                     hit0;
	logic                     hit1;
	logic                     hit2;
	logic                     hit;
	logic                     wr_fire;
	cfg_word_t                rd_word;

	assign word_idx = paddr[ADDR_W-1:2];
	assign hit0 = (paddr[1:0] == 2'h0) &&
		(word_idx == (ADDR_W-2)'(`CFG0_INDEX));
	assign hit1 = (paddr[1:0] == 2'h0) &&
		(word_idx == (ADDR_W-2)'(`CFG1_INDEX));
	assign hit2 = (paddr[1:0] == 2'h0) &&
		(word_idx == (ADDR_W-2)'(`CFG2_INDEX));
	assign hit  = hit0 | hit1 | hit2;

	// data is latched in the setup cycle, so the access answers at once
	assign pready  = ce & setup_done_r;
	assign pslverr = psel & penable & pready & ~hit;
	assign wr_fire = psel & penable & pready & pwrite;

	always_comb begin
		rd_word = '0;
		if (hit0)
			rd_word = cfg0_r;
		else if (hit1)
			rd_word = cfg1_r;
		else if (hit2)
			rd_word = cfg2_r;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			setup_done_r <= 1'b0;
			prdata       <= 32'h0;
		end else if (ce) begin
			setup_done_r <= psel & ~penable;
			if (psel && !penable)
				prdata <= {8'h00, rd_word};
		end
	end

	// reserved and fixed bits ignore writes and hold their reset state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg0_r <= `CFG0_RESET;
			cfg1_r <= `CFG1_RESET;
			cfg2_r <= `CFG2_RESET;
		end else if (ce && wr_fire) begin
			if (hit0)
				cfg0_r <= (pwdata[`CFG_W-1:0] & `CFG0_WMASK) |
					(`CFG0_RESET & ~`CFG0_WMASK);
			if (hit1)
				cfg1_r <= (pwdata[`CFG_W-1:0] & `CFG1_WMASK) |
					(`CFG1_RESET & ~`CFG1_WMASK);
			if (hit2)
				cfg2_r <= (pwdata[`CFG_W-1:0] & `CFG2_WMASK) |
					(`CFG2_RESET & ~`CFG2_WMASK);
		end
	end

	a_write_masked: assert property (
		ce && wr_fire && hit1 |=> cfg1_r ==
		(($past(pwdata[`CFG_W-1:0]) & `CFG1_WMASK) |
		(`CFG1_RESET & ~`CFG1_WMASK)))
		else $error("config word one write not masked");
	a_unmapped_err: assert property (
		psel && penable && pready && !hit |-> pslverr ##1
		($stable(cfg0_r) && $stable(cfg1_r) && $stable(cfg2_r)))
		else $error("unmapped access without error or changed a word");
	a_fixed_bits: assert property (
		(cfg0_r & ~`CFG0_WMASK) == (`CFG0_RESET & ~`CFG0_WMASK))
		else $error("fixed bits of config word zero changed");

	// ----------------------------------------------------------------
	// static configuration fields
	// ----------------------------------------------------------------
	assign cur1_amp_gain = cfg0_r[`C0_CUR1_GAIN +: 2];
	assign cur2_amp_gain = cfg0_r[`C0_CUR2_GAIN +: 2];
	assign xtal_disable  = cfg0_r[`C0_XTAL_OFF];
	assign pulse_gen_enable = cfg1_r[`C1_PGEN_EN +: 3];
	assign fixed_voltage_ref     = cfg2_r[`C2_FIXED_VOLTAGE_REF];
	assign apparent_power_method = cfg2_r[`C2_APPARENT_POWER_METHOD];
	assign averaging_select      = cfg2_r[`C2_AVG];
	// the line-cycle count replaces the sample count in the checksum
	assign checksum_line_cycles  = cfg2_r[`C2_AVG];
	assign critical_checksum_disable = cfg2_r[`C2_CSUM_OFF];
	assign cur1_filter_sel  = cfg2_r[`C2_CUR1_FILTER_SEL +: 2];
	assign cur2_filter_sel  = cfg2_r[`C2_CUR2_FILTER_SEL +: 2];
	assign volt1_filter_sel = cfg2_r[`C2_VOLT1_FILTER_SEL +: 2];
	assign volt2_filter_sel = cfg2_r[`C2_VOLT2_FILTER_SEL +: 2];
	assign iir_bypass       = cfg2_r[`C2_IIR_BYPASS];

	// ----------------------------------------------------------------
	// interrupt polarity
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			irq_out <= 1'b1;
		else if (ce)
			irq_out <= irq_event ^ ~cfg0_r[`C0_IRQ_POL];
	end

	a_irq_level: assert property (
		$past(ce) |-> irq_out ==
		($past(irq_event) == $past(cfg0_r[`C0_IRQ_POL])))
		else $error("interrupt level does not follow polarity");

	// ----------------------------------------------------------------
	// zero-cross selection and filter
	// ----------------------------------------------------------------
	logic [`ZX_FILT_LEN-1:0] cur_zx_hist_r;
	logic [`ZX_FILT_LEN-1:0] volt_zx_hist_r;
	logic                    cur_zx_filt_r;
	logic                    volt_zx_filt_r;
	logic                    cur_zx_raw;

	assign cur_zx_raw = cfg0_r[`C0_IZX_SEL] ? cur2_zero_cross_in :
		cur1_zero_cross_in;

	// the filter trades a few cycles of delay for glitch rejection
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cur_zx_hist_r  <= '0;
			volt_zx_hist_r <= '0;
			cur_zx_filt_r  <= 1'b0;
			volt_zx_filt_r <= 1'b0;
		end else if (ce) begin
			cur_zx_hist_r  <= {cur_zx_hist_r[`ZX_FILT_LEN-2:0],
				cur_zx_raw};
			volt_zx_hist_r <= {volt_zx_hist_r[`ZX_FILT_LEN-2:0],
				volt_zero_cross_in};
			if (&cur_zx_hist_r || ~|cur_zx_hist_r)
				cur_zx_filt_r <= cur_zx_hist_r[0];
			if (&volt_zx_hist_r || ~|volt_zx_hist_r)
				volt_zx_filt_r <= volt_zx_hist_r[0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cur_zero_cross_out  <= 1'b0;
			volt_zero_cross_out <= 1'b0;
		end else if (ce) begin
			cur_zero_cross_out  <= cfg2_r[`C2_ZERO_CROSS_LOWPASS] ?
				cur_zx_filt_r : cur_zx_raw;
			volt_zero_cross_out <= cfg2_r[`C2_ZERO_CROSS_LOWPASS] ?
				volt_zx_filt_r : volt_zero_cross_in;
		end
	end

	a_zx_select: assert property (
		$past(ce) && !$past(cfg2_r[`C2_ZERO_CROSS_LOWPASS]) |->
		cur_zero_cross_out == ($past(cfg0_r[`C0_IZX_SEL]) ?
		$past(cur2_zero_cross_in) : $past(cur1_zero_cross_in)))
		else $error("current zero-cross not from selected channel");

	// ----------------------------------------------------------------
	// digital output pins
	// ----------------------------------------------------------------
	function automatic logic [1:0] pin_source(
		input logic [`SRC_W-1:0] code,
		input logic [2:0]        pgen,
		input logic [5:0]        sgn,
		input logic              vzx,
		input logic              czx,
		input logic              irq);
		logic [1:0] res;
		res = 2'b00;
		if (code <= `SRC_PGEN_LAST)
			res = {1'b1, pgen[code[1:0]]};
		else if (code >= `SRC_SIGN_FIRST &&
			code <= `SRC_SIGN_LAST)
			res = {1'b1, sgn[3'(code - `SRC_SIGN_FIRST)]};
		else if (code == `SRC_VOLT_ZX)
			res = {1'b1, vzx};
		else if (code == `SRC_CUR_ZX)
			res = {1'b1, czx};
		else if (code == `SRC_IRQ)
			res = {1'b1, irq};
		return res;
	endfunction : pin_source

	logic [2:0] pgen_gated;
	logic [1:0] pin_sel [3];

	// a disabled generator never reaches a pin
	assign pgen_gated = pulse_gen_in & cfg1_r[`C1_PGEN_EN +: 3];

	always_comb begin
		for (int i = 0; i < 3; i++)
			pin_sel[i] = pin_source(cfg1_r[`C1_SRC + `SRC_W*i +: `SRC_W],
				pgen_gated, power_sign_in, volt_zero_cross_out,
				cur_zero_cross_out, irq_out);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_pin_o    <= 3'h0;
			out_pin_oe_n <= 3'h7;
		end else if (ce) begin
			for (int i = 0; i < 3; i++) begin
				// hi-z and reserved codes leave the pin undriven
				if (!pin_sel[i][1]) begin
					out_pin_o[i]    <= 1'b0;
					out_pin_oe_n[i] <= 1'b1;
				end else if (cfg1_r[`C1_OPEN_DRAIN + i]) begin
					out_pin_o[i]    <= 1'b0;
					out_pin_oe_n[i] <= pin_sel[i][0];
				end else begin
					out_pin_o[i]    <= pin_sel[i][0];
					out_pin_oe_n[i] <= 1'b0;
				end
			end
		end
	end

	a_open_drain: assert property (
		$past(ce) && $past(cfg1_r[`C1_OPEN_DRAIN]) |->
		out_pin_o[0] == 1'b0)
		else $error("open-drain pin drives high");
	a_hiz_code: assert property (
		ce && cfg1_r[`C1_SRC +: `SRC_W] == `SRC_HIZ |=>
		out_pin_oe_n[0])
		else $error("hi-z code drives the pin");
	a_pgen_route: assert property (
		ce && cfg1_r[`C1_SRC +: `SRC_W] == 4'h0 &&
		!cfg1_r[`C1_OPEN_DRAIN] |=> !out_pin_oe_n[0] &&
		out_pin_o[0] == $past(pulse_gen_in[0] &
		cfg1_r[`C1_PGEN_EN]))
		else $error("pulse generator one not routed to pin");

	// ----------------------------------------------------------------
	// positive-only clamp
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			p1_avg_out <= '0;
			p2_avg_out <= '0;
		end else if (ce) begin
			p1_avg_out <= (cfg2_r[`C2_POS] && p1_avg_in[POW_W-1]) ?
				'0 : p1_avg_in;
			p2_avg_out <= (cfg2_r[`C2_POS] && p2_avg_in[POW_W-1]) ?
				'0 : p2_avg_in;
		end
	end

	a_pos_clamp: assert property (
		ce && cfg2_r[`C2_POS] && p2_avg_in[POW_W-1] |=>
		p2_avg_out == '0)
		else $error("negative power not clamped to zero");

	// ----------------------------------------------------------------
	// summed power channel choice
	// ----------------------------------------------------------------
	logic ch2_larger;

	// signed compare on power, unsigned magnitude on rms current
	assign ch2_larger = cfg2_r[`C2_COMPARE_BY_RMS_CURRENT] ?
		(i2_rms_in > i1_rms_in) :
		($signed(p2_avg_in) > $signed(p1_avg_in));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sum_use_ch2 <= 1'b0;
			sum_average <= 1'b0;
		end else if (ce) begin
			sum_average <= cfg2_r[`C2_METER_TOPOLOGY +: 2] ==
				`METER_TOPOLOGY_AVERAGE;
			if (cfg2_r[`C2_METER_TOPOLOGY +: 2] != `METER_TOPOLOGY_SINGLE)
				sum_use_ch2 <= 1'b0;
			else if (cfg2_r[`C2_MANUAL_CHANNEL_HOLD])
				sum_use_ch2 <= cfg2_r[`C2_ICHAN];
			else
				sum_use_ch2 <= ch2_larger;
		end
	end

	a_manual_hold: assert property (
		ce && cfg2_r[`C2_METER_TOPOLOGY +: 2] == `METER_TOPOLOGY_SINGLE &&
		cfg2_r[`C2_MANUAL_CHANNEL_HOLD] |=> sum_use_ch2 == $past(cfg2_r[`C2_ICHAN]))
		else $error("held channel choice ignored");
	a_sum_average: assert property (
		ce && cfg2_r[`C2_METER_TOPOLOGY +: 2] == `METER_TOPOLOGY_AVERAGE |=>
		sum_average && !sum_use_ch2)
		else $error("average topology not applied");

	// ----------------------------------------------------------------
	// automatic line frequency
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			epsilon_update <= 1'b0;
		else if (ce)
			epsilon_update <= freq_meas_done &
				cfg2_r[`C2_AFC];
	end

	a_eps_update: assert property (
		ce && freq_meas_done && cfg2_r[`C2_AFC] |=> epsilon_update)
		else $error("frequency measurement did not update gain");
	a_eps_blocked: assert property (
		epsilon_update |-> $past(cfg2_r[`C2_AFC]))
		else $error("gain updated while tracking disabled");

endmodule : meter_config_registers
`default_nettype wire
